// [inc/alc_pkg.sv]
// Purpose: shared constants of the audio link control block
// Assumes: 32-bit classic Wishbone, one register per aligned word
// Notes: register byte address is four times the register index
`default_nettype none

package alc_pkg;

  // register indices, byte address = index * 4
  localparam logic [13:0] IDX_VOLUME = 14'h0001;
  localparam logic [13:0] IDX_MIC_COARSE = 14'h03d3;
  localparam logic [13:0] IDX_AUDIO_CTRL = 14'h0400;
  localparam logic [13:0] IDX_REMOTE_STAT = 14'h0419;
  localparam logic [13:0] IDX_SPK_SCALE = 14'h0990;
  localparam logic [13:0] IDX_ECHO_CTRL = 14'h0a5c;
  localparam logic [13:0] IDX_MIC_FINE = 14'h0b7e;

  // field positions
  localparam int VOL_LSB = 6;
  localparam int MICC_LSB = 1;
  localparam int CTL_SQUELCH = 2;
  localparam int CTL_HANDSET = 5;
  localparam int CTL_AGC = 6;
  localparam int CTL_HDX = 7;
  localparam int STAT_ONHOOK = 7;
  localparam int EC_CMD_BIT = 15;
  localparam int EC_ACT_BIT = 14;

  // values after reset
  localparam logic [1:0] VOL_RST = 2'h0;
  localparam logic [1:0] MICC_RST = 2'h0;
  localparam logic [7:0] CTL_RST = 8'h00;
  localparam logic [15:0] MIC_FINE_RST = 16'h0800;
  localparam logic [15:0] SPK_SCALE_RST = 16'hf000;
  localparam logic [13:0] EC_LOW_RST = 14'h0000;

  // coarse microphone gain in dB per code 00..11
  localparam logic [4:0] MICC_DB0 = 5'h00;
  localparam logic [4:0] MICC_DB1 = 5'h0a;
  localparam logic [4:0] MICC_DB2 = 5'h0f;
  localparam logic [4:0] MICC_DB3 = 5'h14;

  // speaker attenuation in dB per volume code 01..11
  localparam logic [3:0] VOL_ATT1 = 4'h0;
  localparam logic [3:0] VOL_ATT2 = 4'h6;
  localparam logic [3:0] VOL_ATT3 = 4'hc;

  // fine microphone gain table, +10 dB down to -10 dB in 2 dB steps
  localparam int MIC_STEPS = 11;
  localparam logic signed [4:0] MIC_DB_TOP = 5'sh0a;
  localparam logic signed [4:0] MIC_DB_STEP = 5'sh02;
  localparam logic [15:0] MIC_DB_CODE [0:10] = '{
    16'h1500, 16'h1200, 16'h0f00, 16'h0c00, 16'h0a00, 16'h0800,
    16'h0500, 16'h0200, 16'hff00, 16'hfd00, 16'hfa00};

  // half-duplex gain control ducking
  localparam logic [7:0] HDX_MARGIN = 8'h10;
  localparam logic [1:0] DUCK_NONE = 2'h0;
  localparam logic [1:0] DUCK_MILD = 2'h1;
  localparam logic [1:0] DUCK_DEEP = 2'h2;

  // bus slave states
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK = 2'b10
  } alc_bus_e;

endpackage

`default_nettype wire

// [design/alc_hdx_gain.sv]
// Purpose: half-duplex gain control, ducks the quieter audio direction
// Assumes: level inputs are envelope values, larger is louder
// Notes: never mutes a direction, so the path stays full duplex
`timescale 1ns/1ps
`default_nettype none

module alc_hdx_gain (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // control
  input wire logic hdxEnable,
  // audio levels
  input wire logic [7:0] micLevel,
  input wire logic [7:0] spkLevel,
  // gain adjustments
  output logic [1:0] micDuck,
  output logic [1:0] spkDuck
);

  typedef struct packed {
    logic [1:0] micDuck;
    logic [1:0] spkDuck;
  } alc_hdx_s;

  alc_hdx_s st_reg;
  alc_hdx_s st_next;
  logic [8:0] micPlus;
  logic [8:0] spkPlus;

  // compare levels with a margin, re-evaluated every cycle
  always_comb
  begin
    micPlus = {1'b0, micLevel} + {1'b0, alc_pkg::HDX_MARGIN};
    spkPlus = {1'b0, spkLevel} + {1'b0, alc_pkg::HDX_MARGIN};
    st_next = st_reg;
    if (!hdxEnable)
    begin
      st_next.micDuck = alc_pkg::DUCK_NONE;
      st_next.spkDuck = alc_pkg::DUCK_NONE;
    end
    else if ({1'b0, spkLevel} > micPlus)
    begin
      st_next.micDuck = alc_pkg::DUCK_DEEP; // far talker dominant
      st_next.spkDuck = alc_pkg::DUCK_NONE;
    end
    else if ({1'b0, micLevel} > spkPlus)
    begin
      st_next.micDuck = alc_pkg::DUCK_NONE;
      st_next.spkDuck = alc_pkg::DUCK_DEEP; // near talker dominant
    end
    else
    begin
      st_next.micDuck = alc_pkg::DUCK_MILD; // double talk, both open
      st_next.spkDuck = alc_pkg::DUCK_MILD;
    end
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end

  assign micDuck = st_reg.micDuck;
  assign spkDuck = st_reg.spkDuck;

  chk_hdx_full_duplex: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !(micDuck == alc_pkg::DUCK_DEEP && spkDuck == alc_pkg::DUCK_DEEP))
    else $error("both directions ducked deep");

  chk_hdx_off_clean: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !hdxEnable ##1 1'b1 |-> micDuck == alc_pkg::DUCK_NONE && spkDuck == alc_pkg::DUCK_NONE)
    else $error("ducking active while gain control off");

endmodule // alc_hdx_gain

`default_nettype wire

// [design/alc_audio_link_ctrl.sv]
// Purpose: audio path settings and audio link signalling of a data pump
// Assumes: registers reached over classic Wishbone, inputs synchronous
// Notes: remote squelch state arrives already decoded from the line
//
// Added by the designer: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

// Function
// - coarse mic gain code gives 0/10/15/20 dB
// - fine mic gain resets on renegotiate, connected-only writes
// - fine mic gain word maps 2 dB steps
// - gain change follows multiplier log difference
// - handset uses fine words, ignores volume/coarse
// - echo write 8004 enables, reads 0004/4004
// - handset mode, speaker scale defaults F000
// - local squelch set makes remote on-hook
// - local squelch clear clears remote on-hook
// - ring only squelch set, remote off-hook
// - ringback only squelch clear, remote on-hook
// - half-duplex control adjusts gains, stays duplex
// - speaker volume code off/0/6/12 dB
module alc_audio_link_ctrl (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [15:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // link status and events
  input wire logic linkConnected,
  input wire logic rate_renegotiate_request,
  input wire logic retrain_request,
  input wire logic remoteSquelchIn,
  output logic localSquelchOut,
  // audio levels for half-duplex control
  input wire logic [7:0] micLevel,
  input wire logic [7:0] spkLevel,
  // audio path settings
  output logic [4:0] micCoarseGainDb,
  output logic [15:0] micFineGainWord,
  output logic signed [4:0] micRelGainDb,
  output logic spkEnable,
  output logic [3:0] spkAttenDb,
  output logic [15:0] spkScaleWord,
  output logic handsetPathSel,
  output logic micAgcEnable,
  output logic echoCancelActive,
  output logic [1:0] micDuck,
  output logic [1:0] spkDuck,
  // tone gating
  output logic ringToneOn,
  output logic ringbackToneOn
);

  typedef struct packed {
    alc_pkg::alc_bus_e busState;
    logic [31:0] rdData;
    logic [1:0] volume;
    logic [1:0] micCoarse;
    logic [7:0] audioCtrl;
    logic remoteOnHook;
    logic [15:0] spkScale;
    logic ecEnable;
    logic [13:0] ecLow;
    logic [15:0] micFine;
    logic [4:0] micCoarseDb;
    logic signed [4:0] micRelDb;
    logic spkEn;
    logic [3:0] spkAtt;
    logic ecActive;
    logic ring;
    logic ringback;
    logic squelchOut;
  } alc_main_s;

  alc_main_s st_reg;
  alc_main_s st_next;
  logic [13:0] regIdx;
  logic busReq;
  logic wrStrobe;
  logic handset;
  logic [15:0] wrWord16;
  logic [7:0] wrByte;
  logic [15:0] ecRead;

  assign regIdx = wb_adr_i[15:2];
  assign busReq = wb_cyc_i && wb_stb_i;

  // merge a 16-bit register with write data under byte enables
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    logic [15:0] res;
    res = old;
    if (sel[0])
      res[7:0] = d[7:0];
    if (sel[1])
      res[15:8] = d[15:8];
    return res;
  endfunction

  // next state: bus slave, register writes, derived path settings
  always_comb
  begin
    st_next = st_reg;
    wrStrobe = 1'b0;
    handset = st_reg.audioCtrl[alc_pkg::CTL_HANDSET];
    wrWord16 = 16'h0000;
    wrByte = wb_dat_i[7:0];
    ecRead = {1'b0, st_reg.ecActive, st_reg.ecLow};
    case (st_reg.busState)
      alc_pkg::BUS_IDLE:
      begin
        if (busReq)
        begin
          st_next.busState = alc_pkg::BUS_ACK;
          wrStrobe = wb_we_i;
          st_next.rdData = 32'h0000_0000;
          case (regIdx)
            alc_pkg::IDX_VOLUME:
              st_next.rdData[7:0] = {st_reg.volume, 6'h00};
            alc_pkg::IDX_MIC_COARSE:
              st_next.rdData[7:0] = {5'h00, st_reg.micCoarse, 1'b0};
            alc_pkg::IDX_AUDIO_CTRL:
              st_next.rdData[7:0] = st_reg.audioCtrl;
            alc_pkg::IDX_REMOTE_STAT:
              st_next.rdData[7:0] = {st_reg.remoteOnHook, 7'h00};
            alc_pkg::IDX_SPK_SCALE:
              st_next.rdData[15:0] = st_reg.spkScale;
            alc_pkg::IDX_ECHO_CTRL:
              st_next.rdData[15:0] = ecRead; // command bit reads back low
            alc_pkg::IDX_MIC_FINE:
              st_next.rdData[15:0] = st_reg.micFine;
            default:
              st_next.rdData = 32'h0000_0000;
          endcase
        end
      end
      alc_pkg::BUS_ACK:
        st_next.busState = alc_pkg::BUS_IDLE;
      default:
        st_next.busState = alc_pkg::BUS_IDLE;
    endcase

    // register writes; byte lane 0 holds the 8-bit registers
    if (wrStrobe && wb_sel_i[0])
    begin
      case (regIdx)
        alc_pkg::IDX_VOLUME:
          st_next.volume = wrByte[alc_pkg::VOL_LSB +: 2];
        alc_pkg::IDX_MIC_COARSE:
          st_next.micCoarse = wrByte[alc_pkg::MICC_LSB +: 2];
        alc_pkg::IDX_AUDIO_CTRL:
          st_next.audioCtrl = wrByte;
        default:
          st_next.volume = st_next.volume;
      endcase
    end
    if (wrStrobe && regIdx == alc_pkg::IDX_SPK_SCALE && linkConnected)
      st_next.spkScale = merge16(st_reg.spkScale, wb_dat_i, wb_sel_i);
    if (wrStrobe && regIdx == alc_pkg::IDX_MIC_FINE && linkConnected)
      st_next.micFine = merge16(st_reg.micFine, wb_dat_i, wb_sel_i);
    if (wrStrobe && regIdx == alc_pkg::IDX_ECHO_CTRL)
    begin
      wrWord16 = merge16({st_reg.ecEnable, 1'b0, st_reg.ecLow}, wb_dat_i, wb_sel_i);
      st_next.ecEnable = wrWord16[alc_pkg::EC_CMD_BIT]; // 8004 on, 0000 off
      st_next.ecLow = wrWord16[13:0];
    end

    // renegotiation restores both fine gain words, retrain only the speaker scale word
    if (rate_renegotiate_request)
    begin
      st_next.micFine = alc_pkg::MIC_FINE_RST;
      st_next.spkScale = alc_pkg::SPK_SCALE_RST;
    end
    if (retrain_request)
      st_next.spkScale = alc_pkg::SPK_SCALE_RST;

    // remote squelch mirrors into the on-hook status while the link is connected
    st_next.remoteOnHook = linkConnected && remoteSquelchIn;
    st_next.squelchOut = st_reg.audioCtrl[alc_pkg::CTL_SQUELCH];

    // echo canceller only runs connected and in handset mode
    st_next.ecActive = st_reg.ecEnable && handset && linkConnected;

    // coarse mic gain, ignored on the handset path
    case (handset ? alc_pkg::MICC_RST : st_reg.micCoarse)
      2'h0: st_next.micCoarseDb = alc_pkg::MICC_DB0;
      2'h1: st_next.micCoarseDb = alc_pkg::MICC_DB1;
      2'h2: st_next.micCoarseDb = alc_pkg::MICC_DB2;
      2'h3: st_next.micCoarseDb = alc_pkg::MICC_DB3;
      default: st_next.micCoarseDb = alc_pkg::MICC_DB0;
    endcase

    // speaker volume code, ignored on the handset path
    st_next.spkEn = 1'b1;
    case (st_reg.volume)
      2'h0: st_next.spkEn = handset; // speaker off
      2'h1: st_next.spkAtt = alc_pkg::VOL_ATT1;
      2'h2: st_next.spkAtt = alc_pkg::VOL_ATT2;
      2'h3: st_next.spkAtt = alc_pkg::VOL_ATT3;
      default: st_next.spkAtt = alc_pkg::VOL_ATT1;
    endcase
    if (handset || st_reg.volume == 2'h0)
      st_next.spkAtt = alc_pkg::VOL_ATT1;

    // fine gain word to relative dB; unlisted codes keep the last value
    for (int i = 0; i < alc_pkg::MIC_STEPS; i++)
    begin
      if (st_reg.micFine == alc_pkg::MIC_DB_CODE[i])
        st_next.micRelDb = alc_pkg::MIC_DB_TOP - 5'(i) * alc_pkg::MIC_DB_STEP;
    end

    // tone gating from squelch and remote on-hook, every cycle
    st_next.ring = st_reg.audioCtrl[alc_pkg::CTL_SQUELCH] && !st_reg.remoteOnHook;
    st_next.ringback = !st_reg.audioCtrl[alc_pkg::CTL_SQUELCH] && st_reg.remoteOnHook;
  end

  // state register
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      st_reg <= '0;
      st_reg.busState <= alc_pkg::BUS_IDLE;
      st_reg.volume <= alc_pkg::VOL_RST;
      st_reg.micCoarse <= alc_pkg::MICC_RST;
      st_reg.audioCtrl <= alc_pkg::CTL_RST;
      st_reg.spkScale <= alc_pkg::SPK_SCALE_RST;
      st_reg.micFine <= alc_pkg::MIC_FINE_RST;
      st_reg.ecLow <= alc_pkg::EC_LOW_RST;
      st_reg.spkAtt <= alc_pkg::VOL_ATT1;
    end
    else
      st_reg <= st_next;
  end

  // half-duplex gain control
  alc_hdx_gain u_hdx (
    .core_clk(core_clk),
    .sys_rst(sys_rst),
    .hdxEnable(st_reg.audioCtrl[alc_pkg::CTL_HDX]),
    .micLevel(micLevel),
    .spkLevel(spkLevel),
    .micDuck(micDuck),
    .spkDuck(spkDuck)
  );

  // outputs straight from state
  assign wb_dat_o = st_reg.rdData;
  assign wb_ack_o = (st_reg.busState == alc_pkg::BUS_ACK);
  assign localSquelchOut = st_reg.squelchOut;
  assign micCoarseGainDb = st_reg.micCoarseDb;
  assign micFineGainWord = st_reg.micFine; // multiplier word for the gain stage
  assign micRelGainDb = st_reg.micRelDb;
  assign spkEnable = st_reg.spkEn;
  assign spkAttenDb = st_reg.spkAtt;
  assign spkScaleWord = st_reg.spkScale;
  assign handsetPathSel = st_reg.audioCtrl[alc_pkg::CTL_HANDSET];
  assign micAgcEnable = st_reg.audioCtrl[alc_pkg::CTL_AGC];
  assign echoCancelActive = st_reg.ecActive;
  assign ringToneOn = st_reg.ring;
  assign ringbackToneOn = st_reg.ringback;

  chk_ring_gate: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    ringToneOn == ($past(st_reg.audioCtrl[alc_pkg::CTL_SQUELCH]) && !$past(st_reg.remoteOnHook)))
    else $error("ring gating wrong");

  chk_ringback_gate: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (st_reg.remoteOnHook && !st_reg.audioCtrl[alc_pkg::CTL_SQUELCH]) |=> ringbackToneOn)
    else $error("ringback missing");

  chk_tones_exclusive: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    !(ringToneOn && ringbackToneOn))
    else $error("ring and ringback together");

  chk_squelch_out: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $rose(st_reg.audioCtrl[alc_pkg::CTL_SQUELCH]) |=> localSquelchOut)
    else $error("squelch not sent");

  chk_squelch_clear: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    $fell(st_reg.audioCtrl[alc_pkg::CTL_SQUELCH]) |=> !localSquelchOut)
    else $error("squelch clear not sent");

  chk_fine_reneg: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    rate_renegotiate_request |=> micFineGainWord == 16'h0800 && spkScaleWord == 16'hf000)
    else $error("fine gain not restored");

  chk_fine_locked: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (!linkConnected && !rate_renegotiate_request) |=> $stable(micFineGainWord))
    else $error("fine gain changed while disconnected");

  chk_coarse_map: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (st_reg.micCoarse == 2'h3 && !handsetPathSel) ##1 $stable(st_reg.micCoarse)
      |-> micCoarseGainDb == 5'h14)
    else $error("coarse gain code wrong");

  chk_handset_route: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    handsetPathSel ##1 handsetPathSel |-> micCoarseGainDb == 5'h00 && spkAttenDb == 4'h0)
    else $error("handset path uses volume or coarse gain");

  chk_echo_readback: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    wb_ack_o && !$past(wb_we_i) && $past(regIdx) == alc_pkg::IDX_ECHO_CTRL
      |-> !wb_dat_o[alc_pkg::EC_CMD_BIT]
        && wb_dat_o[alc_pkg::EC_ACT_BIT] == $past(echoCancelActive))
    else $error("echo readback wrong");

  chk_fine_db: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    micFineGainWord == 16'hfa00 ##1 $stable(micFineGainWord) |-> micRelGainDb == -5'sd10)
    else $error("fine gain dB wrong");

  chk_volume_off: assert property (
    @(posedge core_clk) disable iff (sys_rst)
    (st_reg.volume == 2'h0 && !handsetPathSel) ##1 (st_reg.volume == 2'h0) |-> !spkEnable)
    else $error("speaker on at volume zero");

endmodule // alc_audio_link_ctrl

`default_nettype wire

// [verif/alc_remote_modem.sv]
// Purpose: far modem across the line, answers the local squelch state
// Assumes: bench commands the far squelch; slowAnswer adds line delay
// Notes: far side keeps its own copy of the local squelch as on-hook
`timescale 1ns/1ps
`default_nettype none

module alc_remote_modem (
  // clock and reset
  input wire logic core_clk,
  input wire logic sys_rst,
  // bench commands
  input wire logic farWantsSquelch,
  input wire logic slowAnswer,
  // line side
  input wire logic localSquelchOut,
  output logic remoteSquelchIn,
  output logic farOnHook
);
  logic [2:0] pipeReg;

  // far squelch travels down the line, short or long delay
  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
    begin
      pipeReg <= 3'h0; // never squelches unless told
      farOnHook <= 1'b0;
    end
    else
    begin
      pipeReg <= {pipeReg[1:0], farWantsSquelch}; // far squelch command shifts down the line
      farOnHook <= localSquelchOut;
    end
  end

  assign remoteSquelchIn = slowAnswer ? pipeReg[2] : pipeReg[0];
endmodule // alc_remote_modem

`default_nettype wire

// [verif/tb_top.sv]
// Purpose: self-checking bench of the audio link control block
// Assumes: classic Wishbone master, 100 MHz clock, fixed random seed
// Notes: expected values come from the bench's own tables
`timescale 1ns/1ps
`default_nettype none

module tb_top;
  logic core_clk, sys_rst, wbCyc, wbStb, wbWe, linkConnected, reneg, retrain;
  logic [15:0] wbAdr;
  logic [3:0] wbSel;
  logic [31:0] wbDatI, wbDatO, rdVal;
  logic wbAck, remoteSquelchIn, localSquelchOut, farWants, slowAns, farOnHook;
  logic [7:0] micLevel, spkLevel;
  logic [4:0] micCoarseGainDb;
  logic [15:0] micFineGainWord, spkScaleWord;
  logic signed [4:0] micRelGainDb;
  logic spkEnable, handsetPathSel, micAgcEnable, echoActive, ringOn, ringbackOn;
  logic [3:0] spkAttenDb;
  logic [1:0] micDuck, spkDuck;
  logic randLevels;
  integer seed;
  int errTotal, numChecks, cycleCount, k;

  alc_audio_link_ctrl i_dut (.core_clk(core_clk), .sys_rst(sys_rst), .wb_cyc_i(wbCyc),
    .wb_stb_i(wbStb), .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .linkConnected(linkConnected),
    .rate_renegotiate_request(reneg), .retrain_request(retrain),
    .remoteSquelchIn(remoteSquelchIn), .localSquelchOut(localSquelchOut),
    .micLevel(micLevel), .spkLevel(spkLevel), .micCoarseGainDb(micCoarseGainDb),
    .micFineGainWord(micFineGainWord), .micRelGainDb(micRelGainDb), .spkEnable(spkEnable),
    .spkAttenDb(spkAttenDb), .spkScaleWord(spkScaleWord), .handsetPathSel(handsetPathSel),
    .micAgcEnable(micAgcEnable), .echoCancelActive(echoActive), .micDuck(micDuck),
    .spkDuck(spkDuck), .ringToneOn(ringOn), .ringbackToneOn(ringbackOn));

  alc_remote_modem i_far (.core_clk(core_clk), .sys_rst(sys_rst), .farWantsSquelch(farWants),
    .slowAnswer(slowAns), .localSquelchOut(localSquelchOut),
    .remoteSquelchIn(remoteSquelchIn), .farOnHook(farOnHook));

  // clock and cycle ceiling
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk)
  begin
    cycleCount <= cycleCount + 1;
    if (randLevels)
    begin
      micLevel <= 8'($random(seed));
      spkLevel <= 8'($random(seed));
    end
    if (cycleCount == 20000)
    begin
      errTotal++;
      testDone();
    end
  end

  // expected fine gain table, 2 dB steps from +10 dB
  function automatic logic [15:0] fineCode(input int i);
    case (i)
      0: return 16'h1500;
      1: return 16'h1200;
      2: return 16'h0f00;
      3: return 16'h0c00;
      4: return 16'h0a00;
      5: return 16'h0800;
      6: return 16'h0500;
      7: return 16'h0200;
      8: return 16'hff00;
      9: return 16'hfd00;
      default: return 16'hfa00;
    endcase
  endfunction

  // expected coarse gain and speaker attenuation per code
  function automatic logic [4:0] coarseDb(input int c);
    return (c == 0) ? 5'h00 : (c == 1) ? 5'h0a : (c == 2) ? 5'h0f : 5'h14;
  endfunction
  function automatic logic [3:0] volAtt(input int c);
    return (c == 2) ? 4'h6 : (c == 3) ? 4'hc : 4'h0;
  endfunction

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp)
    begin
      errTotal++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wbXfer(input logic we, input logic [13:0] idx, input logic [31:0] wd);
    int n;
    n = 0;
    @(posedge core_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= {idx, 2'b00};
    wbSel <= 4'h3;
    wbDatI <= wd;
    do
    begin
      @(posedge core_clk);
      n++;
    end
    while (wbAck !== 1'b1 && n < 50);
    rdVal = wbDatO;
    if (n >= 50)
      chk(32'h0, 32'h1);
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic rdChk(input logic [13:0] idx, input logic [31:0] exp);
    wbXfer(1'b0, idx, 32'h0);
    chk(rdVal, exp);
  endtask

  task automatic waitCyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  task automatic testDone();
    $display("checks %0d mismatches %0d", numChecks, errTotal);
    if (errTotal == 0 && numChecks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  // main sequence
  initial
  begin
    seed = 94884;
    {core_clk, wbCyc, wbStb, wbWe, linkConnected, reneg, retrain, farWants} = 8'h00;
    {slowAns, randLevels} = 2'b01;
    {wbAdr, wbSel, wbDatI, micLevel, spkLevel} = 0;
    {errTotal, numChecks, cycleCount} = 0;
    sys_rst = 1'b1;
    waitCyc(8);
    sys_rst <= 1'b0;
    // reset values and an unmapped place
    rdChk(14'h0b7e, 32'h0800);
    rdChk(14'h0990, 32'hf000);
    wbXfer(1'b1, 14'h03ff, 32'h00ff);
    rdChk(14'h03ff, 32'h0);
    $display("test reset done");
    // coarse gain and volume codes, then handset ignores both
    for (k = 0; k < 4; k++)
    begin
      wbXfer(1'b1, 14'h03d3, 32'(k << 1));
      wbXfer(1'b1, 14'h0001, 32'(k << 6));
      waitCyc(3);
      chk(32'(micCoarseGainDb), 32'(coarseDb(k)));
      chk(32'(spkAttenDb), 32'(volAtt(k)));
      chk(32'(spkEnable), 32'(k != 0));
    end
    wbXfer(1'b1, 14'h0400, 32'h00a0);
    chk(32'(handsetPathSel), 32'h1);
    waitCyc(3);
    chk(32'(micCoarseGainDb), 32'h0);
    chk(32'(spkAttenDb), 32'h0);
    $display("test gain codes done");
    // fine gain: refused off-line, table on-line, restored by events
    wbXfer(1'b1, 14'h0b7e, 32'h1500);
    rdChk(14'h0b7e, 32'h0800);
    linkConnected <= 1'b1;
    for (k = 0; k < 8; k++)
    begin
      int i;
      i = (k == 0) ? 10 : $unsigned($random(seed)) % 11;
      wbXfer(1'b1, 14'h0b7e, 32'(fineCode(i)));
      waitCyc(3);
      chk(32'(micFineGainWord), 32'(fineCode(i)));
      chk(32'(micRelGainDb), 32'(5'(10 - 2 * i)));
    end
    wbXfer(1'b1, 14'h0990, 32'hfa00);
    rdChk(14'h0990, 32'hfa00);
    @(posedge core_clk) reneg <= 1'b1;
    @(posedge core_clk) reneg <= 1'b0;
    rdChk(14'h0b7e, 32'h0800);
    wbXfer(1'b1, 14'h0990, 32'he200);
    @(posedge core_clk) retrain <= 1'b1;
    @(posedge core_clk) retrain <= 1'b0;
    rdChk(14'h0990, 32'hf000);
    chk(32'(spkScaleWord), 32'hf000);
    $display("test fine gain done");
    // echo canceller enable, readback, drop of link, disable
    wbXfer(1'b1, 14'h0a5c, 32'h8004); // enabled only once connected
    rdChk(14'h0a5c, 32'h4004);
    chk(32'(echoActive), 32'h1);
    @(posedge core_clk) linkConnected <= 1'b0;
    waitCyc(3);
    rdChk(14'h0a5c, 32'h0004);
    @(posedge core_clk) linkConnected <= 1'b1;
    wbXfer(1'b1, 14'h0400, 32'h00c0); // leave handset mode
    chk(32'(micAgcEnable), 32'h1);
    chk(32'(handsetPathSel), 32'h0);
    wbXfer(1'b1, 14'h0a5c, 32'h0000); // disable on leaving handset
    rdChk(14'h0a5c, 32'h0);
    chk(32'(echoActive), 32'h0);
    $display("test echo done");
    // half-duplex control ducks the quieter direction only
    randLevels <= 1'b0;
    @(posedge core_clk); // random driver stands down first
    micLevel <= 8'hf0;
    spkLevel <= 8'h10;
    waitCyc(6);
    chk(32'(spkDuck), 32'h2);
    chk(32'(micDuck), 32'h0);
    wbXfer(1'b1, 14'h0400, 32'h0);
    waitCyc(4);
    chk(32'({micDuck, spkDuck}), 32'h0);
    randLevels <= 1'b1;
    $display("test duplex gain done");
    // ring and ringback over all squelch combinations
    for (k = 0; k < 8; k++)
    begin
      wbXfer(1'b1, 14'h0400, 32'((k & 1) << 2));
      farWants <= k[1];
      slowAns <= 1'($random(seed));
      waitCyc(8);
      chk(32'(localSquelchOut), 32'(k & 1));
      chk(32'(farOnHook), 32'(k & 1));
      rdChk(14'h0419, 32'((k & 2) << 6));
      chk(32'(ringOn), 32'(k[0] & ~k[1]));
      chk(32'(ringbackOn), 32'(~k[0] & k[1]));
    end
    $display("test tone gating done");
    testDone();
  end
endmodule // tb_top

`default_nettype wire
